// ===== src/mem_space_pkg.sv
/*
 Package for the memory space access decoder: address widths, map bounds,
 reset values and the packed read/write request carriers.
 Assumes a 16-bit core with a 24-bit program address and a byte-addressed data space.
*/
package mem_space_pkg;
	localparam int PADDR_W = 24;
	localparam int PC_W    = 23;
	localparam int DADDR_W = 16;
	localparam int DATA_W  = 16;
	localparam int WORD_ADDR_W = 13;
	localparam int CFG_WORDS   = 3;

	localparam logic [PADDR_W-1:0] USER_TOP      = 24'h7fffff;
	localparam logic [PADDR_W-1:0] RESET_VECTOR  = 24'h000000;
	localparam logic [PADDR_W-1:0] START_ADDR    = 24'h000002;
	localparam logic [PADDR_W-1:0] IVT_LO        = 24'h000004;
	localparam logic [PADDR_W-1:0] IVT_MID       = 24'h000100;
	localparam logic [PADDR_W-1:0] VECTOR_END    = 24'h000200;
	localparam logic [PADDR_W-1:0] PC_STEP       = 24'h000002;
	localparam int                 PAGE_CFG_BIT  = 7;
	localparam int                 WIN_BIT       = 15;

	localparam logic [DADDR_W-1:0] RAM_BYTES     = 16'h4000;
	localparam logic [DADDR_W-1:0] NEAR_TOP      = 16'h1fff;
	localparam logic [DADDR_W-1:0] BYTE_STEP     = 16'h0001;
	localparam logic [DADDR_W-1:0] WORD_STEP     = 16'h0002;
	localparam logic [DATA_W-1:0]  ZERO_WORD     = 16'h0000;
	localparam int                 RAM_WORDS     = 8192;

	typedef struct packed {
		logic               valid;
		logic               byte_op;
		logic [DADDR_W-1:0] addr;
	} rd_req_t;

	typedef struct packed {
		logic               valid;
		logic               byte_op;
		logic [DADDR_W-1:0] addr;
		logic [DATA_W-1:0]  data;
	} wr_req_t;

	typedef enum logic [1:0] {
		PSRC_PC,
		PSRC_TABLE,
		PSRC_WINDOW
	} psrc_t;

	typedef enum logic [1:0] {
		EXT_NONE,
		EXT_SIGN,
		EXT_ZERO
	} ext_t;
endpackage

// ===== src/memory_space_access_decoder.sv
/*
 Address decoder and byte-lane access logic between the core's address
 generators and the program and data memories.
 Assumes requests and memory answers are synchronous to clk_i; program memory
 answers the same cycle (combinational read data).
*/
`timescale 1ns/100ps

// Notes on behaviour
// RULE_01: Program address is 24 bits from counter/table/window.
// RULE_02: User space to 7FFFFFh; table page bit opens config.
// RULE_03: Even address lower word, odd upper word.
// RULE_04: Program counter even, steps by two.
// RULE_05: Vectors below 000200h; reset starts at zero.
// RULE_06: Two interrupt vector tables decoded.
// RULE_07: Copy top three program words at reset.
// RULE_08: 16-bit byte-addressed data space, split read/write units.
// RULE_09: Address bit 15 selects program window.
// RULE_10: 16 Kbytes RAM; unimplemented reads return zero.
// RULE_11: Low byte even address, high byte odd.
// RULE_12: Post-increment by one for bytes, two words.
// RULE_13: Byte read selects lane onto low byte.
// RULE_14: Shared word decode, per-lane write strobes.
// RULE_15: Odd word access raises address error.
// RULE_16: Misaligned read completes; misaligned write suppressed.
// RULE_17: Byte load changes only register low byte.
// RULE_18: Sign-extend and zero-extend operations provided.
// RULE_19: Near space 0000h-1FFFh via 13-bit field.
// RULE_20: Move reaches whole space via 16-bit field; window hits follow rd_req_i.addr bit 15, not the field.
// RULE_21: Control bit enables program window.
// RULE_22: Address error is a one-cycle request.
module memory_space_access_decoder (
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_i,
	input  wire logic                                  ce_i,
	input  wire logic                                  pc_load_i,
	input  wire logic [mem_space_pkg::PC_W-1:0]        pc_target_i,
	input  wire logic                                  pc_step_i,
	input  wire logic                                  pc_down_i,
	input  wire logic                                  table_op_i,
	input  wire logic [7:0]                            table_page_register_i,
	input  wire logic [15:0]                           table_offset_i,
	input  wire logic [7:0]                            window_page_i,
	input  wire logic                                  window_enable_i,
	input  wire mem_space_pkg::rd_req_t                rd_req_i,
	input  wire mem_space_pkg::wr_req_t                wr_req_i,
	input  wire logic                                  direct_i,
	input  wire logic                                  move_op_i,
	input  wire logic [15:0]                           direct_field_i,
	input  wire logic [mem_space_pkg::DATA_W-1:0]      prog_rdata_i,
	input  wire logic [mem_space_pkg::DATA_W-1:0]      reg_old_i,
	input  wire logic [mem_space_pkg::DATA_W-1:0]      reg_src_i,
	input  wire mem_space_pkg::ext_t                   ext_op_i,
	output logic [mem_space_pkg::PADDR_W-1:0]          prog_addr_o,
	output logic                                       prog_ok_o,
	output logic                                       in_vectors_o,
	output logic                                       in_ivt_o,
	output logic                                       in_alt_ivt_o,
	output logic [mem_space_pkg::PC_W-1:0]             program_counter_o,
	output logic [mem_space_pkg::DATA_W-1:0]           cfg_word0_o,
	output logic [mem_space_pkg::DATA_W-1:0]           cfg_word1_o,
	output logic [mem_space_pkg::DATA_W-1:0]           cfg_word2_o,
	output logic                                       cfg_done_o,
	output logic [mem_space_pkg::DATA_W-1:0]           rd_data_o,
	output logic                                       rd_valid_o,
	output logic [mem_space_pkg::DADDR_W-1:0]          rd_next_ptr_o,
	output logic [mem_space_pkg::DADDR_W-1:0]          wr_next_ptr_o,
	output logic [mem_space_pkg::DATA_W-1:0]           reg_load_o,
	output logic [mem_space_pkg::DATA_W-1:0]           ext_result_o,
	output logic                                       near_o,
	output logic                                       addr_error_o
);
	localparam logic [mem_space_pkg::PADDR_W-1:0] CFG_BASE_W = 24'h02abfa;

	// ==========================================================
	// Helpers
	function automatic logic misaligned(input logic byte_op, input logic [15:0] a);
		misaligned = !byte_op && a[0];
	endfunction

	function automatic logic [15:0] post_inc(input logic byte_op, input logic [15:0] a);
		post_inc = a + (byte_op ? mem_space_pkg::BYTE_STEP : mem_space_pkg::WORD_STEP); // RULE_12
	endfunction

	function automatic logic in_ram(input logic [15:0] a);
		in_ram = !a[mem_space_pkg::WIN_BIT] && (a < mem_space_pkg::RAM_BYTES);
	endfunction

	// ==========================================================
	// Program counter and program address
	logic [mem_space_pkg::PC_W-1:0]    program_counter;
	logic [mem_space_pkg::PADDR_W-1:0] next_pc_wide;

	always_comb begin
		next_pc_wide = {1'b0, program_counter};
		if (pc_step_i)
			next_pc_wide = pc_down_i ? next_pc_wide - mem_space_pkg::PC_STEP
			                         : next_pc_wide + mem_space_pkg::PC_STEP; // RULE_04
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			program_counter <= mem_space_pkg::RESET_VECTOR[mem_space_pkg::PC_W-1:0]; // RULE_05
		else if (ce_i) begin
			if (pc_load_i)
				program_counter <= {pc_target_i[mem_space_pkg::PC_W-1:1], 1'b0}; // RULE_04
			else
				program_counter <= {next_pc_wide[mem_space_pkg::PC_W-1:1], 1'b0};
		end
	end
	assign program_counter_o = program_counter;

	mem_space_pkg::psrc_t psrc;
	logic [mem_space_pkg::PADDR_W-1:0] table_addr;
	logic [mem_space_pkg::PADDR_W-1:0] win_addr;
	logic [mem_space_pkg::PADDR_W-1:0] paddr;
	logic                              win_hit;
	logic [mem_space_pkg::PADDR_W-2:0] cfg_idx;
	logic [mem_space_pkg::DATA_W-1:0]  cfg_mem [mem_space_pkg::CFG_WORDS];

	// Window hit only when the control bit is set
	assign win_hit    = rd_req_i.valid && rd_req_i.addr[mem_space_pkg::WIN_BIT]
	                    && window_enable_i; // RULE_09 RULE_21
	assign table_addr = {table_page_register_i, table_offset_i};
	assign win_addr   = {window_page_i, 1'b0, rd_req_i.addr[14:0]};

	always_comb begin
		if (table_op_i)
			psrc = mem_space_pkg::PSRC_TABLE;
		else if (win_hit)
			psrc = mem_space_pkg::PSRC_WINDOW;
		else
			psrc = mem_space_pkg::PSRC_PC;
		unique case (psrc)
			mem_space_pkg::PSRC_TABLE:  paddr = table_addr;
			mem_space_pkg::PSRC_WINDOW: paddr = win_addr;
			default:                    paddr = {1'b0, program_counter}; // RULE_01
		endcase
	end

	// Config space above the user half is reachable only by table ops with the page bit set
	always_comb begin
		prog_ok_o = (paddr <= mem_space_pkg::USER_TOP)
		            || (table_op_i && table_page_register_i[mem_space_pkg::PAGE_CFG_BIT]); // RULE_02
	end
	assign prog_addr_o  = cfg_done_o ? paddr : CFG_BASE_W + {cfg_idx, 1'b0}; // RULE_03
	assign in_vectors_o = paddr < mem_space_pkg::VECTOR_END; // RULE_05
	assign in_ivt_o     = (paddr >= mem_space_pkg::IVT_LO) && (paddr < mem_space_pkg::IVT_MID); // RULE_06
	assign in_alt_ivt_o = (paddr >= mem_space_pkg::IVT_MID) && (paddr < mem_space_pkg::VECTOR_END); // RULE_06

	// ==========================================================
	// Configuration copy after reset

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_idx    <= '0;
			cfg_done_o <= 1'b0;
			for (int i = 0; i < mem_space_pkg::CFG_WORDS; i++)
				cfg_mem[i] <= mem_space_pkg::ZERO_WORD;
		end else if (ce_i && !cfg_done_o) begin
			cfg_mem[cfg_idx[1:0]] <= prog_rdata_i; // RULE_07
			if (cfg_idx == 23'(mem_space_pkg::CFG_WORDS - 1))
				cfg_done_o <= 1'b1;
			else
				cfg_idx <= cfg_idx + 23'h000001;
		end
	end
	assign cfg_word0_o = cfg_mem[0];
	assign cfg_word1_o = cfg_mem[1];
	assign cfg_word2_o = cfg_mem[2];

	// ==========================================================
	// Data RAM, byte lanes
	logic [7:0] ram_lo [mem_space_pkg::RAM_WORDS];
	logic [7:0] ram_hi [mem_space_pkg::RAM_WORDS];
	logic [mem_space_pkg::DADDR_W-1:0] rd_addr;
	logic [mem_space_pkg::WORD_ADDR_W-1:0] rd_word;
	logic [mem_space_pkg::WORD_ADDR_W-1:0] wr_word;
	logic wr_lo;
	logic wr_hi;
	logic wr_bad;
	logic rd_bad;

	// Direct fields: 13 bits reach only the near space, moves take 16 bits
	always_comb begin
		rd_addr = rd_req_i.addr;
		if (direct_i)
			rd_addr = move_op_i ? direct_field_i // RULE_20
			                    : {3'h0, direct_field_i[12:0]}; // RULE_19
	end
	assign near_o  = rd_addr <= mem_space_pkg::NEAR_TOP; // RULE_19
	assign rd_word = rd_addr[mem_space_pkg::WORD_ADDR_W:1];
	assign wr_word = wr_req_i.addr[mem_space_pkg::WORD_ADDR_W:1]; // RULE_14
	assign rd_bad  = rd_req_i.valid && misaligned(rd_req_i.byte_op, rd_addr); // RULE_15
	assign wr_bad  = wr_req_i.valid && misaligned(wr_req_i.byte_op, wr_req_i.addr); // RULE_15
	// A misaligned write is dropped; a byte write drives only its own lane
	assign wr_lo   = wr_req_i.valid && in_ram(wr_req_i.addr) && !wr_bad
	                 && (!wr_req_i.byte_op || !wr_req_i.addr[0]); // RULE_14 RULE_16
	assign wr_hi   = wr_req_i.valid && in_ram(wr_req_i.addr) && !wr_bad
	                 && (!wr_req_i.byte_op || wr_req_i.addr[0]); // RULE_14 RULE_16

	always_ff @(posedge clk_i) begin
		if (ce_i && wr_lo)
			ram_lo[wr_word] <= wr_req_i.data[7:0]; // RULE_11
		if (ce_i && wr_hi)
			ram_hi[wr_word] <= wr_req_i.byte_op ? wr_req_i.data[7:0]
			                                    : wr_req_i.data[15:8]; // RULE_11
	end

	logic [15:0] word_rd;
	always_comb begin
		if (in_ram(rd_addr))
			word_rd = {ram_hi[rd_word], ram_lo[rd_word]}; // RULE_08
		else if (win_hit)
			word_rd = prog_rdata_i; // RULE_09
		else
			word_rd = mem_space_pkg::ZERO_WORD; // RULE_10
	end

	// Misaligned reads still deliver data so the instruction completes.
	// Size of the answered read is kept: a new request must not re-merge it
	logic rd_byte;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o  <= mem_space_pkg::ZERO_WORD;
			rd_valid_o <= 1'b0;
			rd_byte    <= 1'b0;
		end else if (ce_i) begin
			rd_valid_o <= rd_req_i.valid; // RULE_16
			if (rd_req_i.valid)
				rd_byte <= rd_req_i.byte_op; // RULE_17
			if (rd_req_i.byte_op)
				rd_data_o <= {8'h00, rd_addr[0] ? word_rd[15:8] : word_rd[7:0]}; // RULE_13
			else
				rd_data_o <= word_rd;
		end
	end

	assign rd_next_ptr_o = post_inc(rd_req_i.byte_op, rd_req_i.addr); // RULE_12
	assign wr_next_ptr_o = post_inc(wr_req_i.byte_op, wr_req_i.addr); // RULE_12

	// ==========================================================
	// Register load and extension
	assign reg_load_o = rd_byte ? {reg_old_i[15:8], rd_data_o[7:0]} : rd_data_o; // RULE_17

	always_comb begin
		unique case (ext_op_i)
			mem_space_pkg::EXT_SIGN: ext_result_o = {{8{reg_src_i[7]}}, reg_src_i[7:0]}; // RULE_18
			mem_space_pkg::EXT_ZERO: ext_result_o = {8'h00, reg_src_i[7:0]}; // RULE_18
			default:                 ext_result_o = reg_src_i;
		endcase
	end

	// ==========================================================
	// Address error request
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			addr_error_o <= 1'b0;
		else if (ce_i)
			addr_error_o <= rd_bad || wr_bad; // RULE_22
	end

	// ==========================================================
	// Checks
	// Each accepted store is replayed one edge later against a snapshot of
	// the old word, so a lane or suppression slip shows in the array itself
	logic                                  st_seen;
	logic                                  st_byte;
	logic                                  st_odd;
	logic                                  st_bad;
	logic [mem_space_pkg::WORD_ADDR_W-1:0] st_word;
	logic [mem_space_pkg::DATA_W-1:0]      st_old;
	logic [mem_space_pkg::DATA_W-1:0]      st_data;
	logic [mem_space_pkg::DATA_W-1:0]      st_now;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_seen <= 1'b0;
			st_byte <= 1'b0;
			st_odd  <= 1'b0;
			st_bad  <= 1'b0;
			st_word <= '0;
			st_old  <= mem_space_pkg::ZERO_WORD;
			st_data <= mem_space_pkg::ZERO_WORD;
		end else if (ce_i) begin
			st_seen <= wr_req_i.valid && in_ram(wr_req_i.addr);
			st_byte <= wr_req_i.byte_op;
			st_odd  <= wr_req_i.addr[0];
			st_bad  <= misaligned(wr_req_i.byte_op, wr_req_i.addr);
			st_word <= wr_word;
			st_old  <= {ram_hi[wr_word], ram_lo[wr_word]};
			st_data <= wr_req_i.data;
		end
	end
	assign st_now = {ram_hi[st_word], ram_lo[st_word]};

	a_word_write_odd: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
		st_seen && st_bad |-> st_now == st_old)
		else $error("misaligned write reached memory");

	a_byte_lane: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
		st_seen && !st_bad && st_byte |->
		st_now == (st_odd ? {st_data[7:0], st_old[7:0]} : {st_old[15:8], st_data[7:0]}))
		else $error("byte write touched the wrong lane");

	a_word_store: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
		st_seen && !st_bad && !st_byte |-> st_now == st_data)
		else $error("word write lanes swapped");

	a_error_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
		ce_i && (rd_bad || wr_bad) |=> addr_error_o)
		else $error("address error missed");

	a_error_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_22
		ce_i && !rd_bad && !wr_bad |=> !addr_error_o)
		else $error("spurious address error");

	a_pc_even: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
		!program_counter[0])
		else $error("program counter odd");

	a_pc_step: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
		ce_i && pc_step_i && !pc_load_i && !pc_down_i |=>
		program_counter == 23'($past(program_counter) + mem_space_pkg::PC_STEP))
		else $error("bad pc step");

	a_pc_down: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
		ce_i && pc_step_i && !pc_load_i && pc_down_i |=>
		program_counter == 23'($past(program_counter) - mem_space_pkg::PC_STEP))
		else $error("bad pc step down");

	a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
		ce_i && rd_req_i.valid && !in_ram(rd_addr) && !win_hit |=>
		rd_data_o == mem_space_pkg::ZERO_WORD)
		else $error("unimplemented read not zero");

	a_cfg_done: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
		$rose(cfg_done_o) |-> $past(cfg_idx) == 23'(mem_space_pkg::CFG_WORDS - 1))
		else $error("config copy count");

	a_window_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_21
		ce_i && rd_req_i.valid && rd_addr[mem_space_pkg::WIN_BIT] && !window_enable_i |=>
		rd_data_o == mem_space_pkg::ZERO_WORD)
		else $error("window read while disabled");

	a_byte_upper: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
		ce_i && rd_req_i.valid && rd_req_i.byte_op |=> rd_data_o[15:8] == 8'h00)
		else $error("byte read upper half not clear");

	a_ivt_split: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
		in_ivt_o || in_alt_ivt_o |-> in_vectors_o && !(in_ivt_o && in_alt_ivt_o))
		else $error("vector table decode overlap");

	a_user_space: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
		!table_op_i && !win_hit |-> prog_ok_o)
		else $error("counter fetch outside user space");
endmodule

// ===== tb/prog_mem_model.sv
/*
 Behavioural program memory beside the decoder.
 Assumes the decoder samples read data in the same cycle that it shows the address.
*/
`timescale 1ns/100ps
module prog_mem_model (
	input  wire logic [23:0] addr_i,
	output logic      [15:0] rdata_o
);
	// ==========================================================
	// Word contents
	// Upper word keeps its top byte at zero, as the array has no cells there
	always_comb begin
		if (addr_i[0]) begin
			rdata_o = {8'h00, addr_i[8:1]};
		end else begin
			rdata_o = addr_i[16:1] ^ 16'h3c5a;
		end
	end
endmodule

// ===== tb/memory_space_access_decoder_bench.sv
/*
 Self-checking bench for the memory space access decoder.
 Assumes a same-cycle program memory model and data RAM inside the design.
*/
`timescale 1ns/100ps
module memory_space_access_decoder_bench;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, pc_load_i = 1'b0, pc_step_i = 1'b0;
	logic pc_down_i = 1'b0, table_op_i = 1'b0, window_enable_i = 1'b0;
	logic direct_i = 1'b0, move_op_i = 1'b0;
	logic [22:0] pc_target_i = 23'h000000;
	logic [7:0]  table_page_register_i = 8'h00, window_page_i = 8'h00;
	logic [15:0] table_offset_i = 16'h0000, direct_field_i = 16'h0000;
	logic [15:0] reg_old_i = 16'ha55a, reg_src_i = 16'h0000, prog_rdata_i, r, a;
	mem_space_pkg::rd_req_t rq = '0;
	mem_space_pkg::wr_req_t wq = '0;
	mem_space_pkg::ext_t    ext_op_i = mem_space_pkg::EXT_NONE;
	logic [23:0] prog_addr_o;
	logic [22:0] program_counter_o;
	logic [15:0] cfg_word0_o, cfg_word1_o, cfg_word2_o, rd_data_o, rd_next_ptr_o;
	logic [15:0] wr_next_ptr_o, reg_load_o, ext_result_o;
	logic prog_ok_o, in_vectors_o, in_ivt_o, in_alt_ivt_o, cfg_done_o, rd_valid_o;
	logic near_o, addr_error_o;
	int num_errors = 0, num_checks = 0, i;
	logic [15:0] offs [7] = '{16'h0000, 16'h0002, 16'h0004, 16'h00fe, 16'h0100, 16'h01fe, 16'h0202};
	logic [2:0]  dec [7] = '{3'b100, 3'b100, 3'b110, 3'b110, 3'b101, 3'b101, 3'b000};

	always #2 clk_i = ~clk_i;

	memory_space_access_decoder u_memory_space_access_decoder (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pc_load_i(pc_load_i),
		.pc_target_i(pc_target_i), .pc_step_i(pc_step_i), .pc_down_i(pc_down_i),
		.table_op_i(table_op_i), .table_page_register_i(table_page_register_i),
		.table_offset_i(table_offset_i), .window_page_i(window_page_i),
		.window_enable_i(window_enable_i), .rd_req_i(rq), .wr_req_i(wq),
		.direct_i(direct_i), .move_op_i(move_op_i), .direct_field_i(direct_field_i),
		.prog_rdata_i(prog_rdata_i), .reg_old_i(reg_old_i), .reg_src_i(reg_src_i),
		.ext_op_i(ext_op_i), .prog_addr_o(prog_addr_o), .prog_ok_o(prog_ok_o),
		.in_vectors_o(in_vectors_o), .in_ivt_o(in_ivt_o), .in_alt_ivt_o(in_alt_ivt_o),
		.program_counter_o(program_counter_o), .cfg_word0_o(cfg_word0_o),
		.cfg_word1_o(cfg_word1_o), .cfg_word2_o(cfg_word2_o), .cfg_done_o(cfg_done_o),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_next_ptr_o(rd_next_ptr_o),
		.wr_next_ptr_o(wr_next_ptr_o), .reg_load_o(reg_load_o),
		.ext_result_o(ext_result_o), .near_o(near_o), .addr_error_o(addr_error_o)
	);

	prog_mem_model u_prog_mem_model (.addr_i(prog_addr_o), .rdata_o(prog_rdata_i));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [15:0] pw(input logic [23:0] p);
		return p[0] ? {8'h00, p[8:1]} : p[16:1] ^ 16'h3c5a;
	endfunction

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] wa, input logic [15:0] d, input logic b);
		@(negedge clk_i);
		wq = '{1'b1, b, wa, d};
		#1 chk(wr_next_ptr_o, 16'(wa + (b ? 16'h0001 : 16'h0002)));
		@(negedge clk_i);
		wq.valid = 1'b0;
		chk(addr_error_o, !b && wa[0]);
	endtask

	// Direct reads take their address from the field, so the pointer is not compared then
	task automatic rdc(input logic [15:0] ra, input logic b, input logic [15:0] exp);
		logic [15:0] ea;
		ea = direct_i ? (move_op_i ? direct_field_i : {3'b000, direct_field_i[12:0]}) : ra;
		@(negedge clk_i);
		rq = '{1'b1, b, ra};
		#1 chk(near_o, ea <= 16'h1fff);
		if (!direct_i) chk(rd_next_ptr_o, 16'(ra + (b ? 16'h0001 : 16'h0002)));
		@(negedge clk_i);
		rq.valid = 1'b0;
		chk(rd_valid_o, 1'b1);
		chk(addr_error_o, !b && ea[0]);
		chk(rd_data_o, exp);
		if (b) chk(reg_load_o, {reg_old_i[15:8], exp[7:0]});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		#40000;
		num_errors++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		chk(program_counter_o, 23'h000000);
		chk(prog_addr_o, 24'h02abfa);
		for (i = 0; i < 20 && cfg_done_o !== 1'b1; i++) @(negedge clk_i);
		chk(cfg_done_o, 1'b1);
		chk(cfg_word0_o, pw(24'h02abfa));
		chk(cfg_word1_o, pw(24'h02abfc));
		chk(cfg_word2_o, pw(24'h02abfe));
		$display("test config done");
		pc_load_i = 1'b1;
		pc_target_i = 23'h012345;
		@(negedge clk_i);
		pc_load_i = 1'b0;
		chk(program_counter_o, 23'h012344);
		pc_step_i = 1'b1;
		@(negedge clk_i);
		chk(program_counter_o, 23'h012346);
		pc_down_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk(program_counter_o, 23'h012342);
		chk(prog_addr_o, 24'h012342);
		ce_i = 1'b0;
		@(negedge clk_i);
		chk(program_counter_o, 23'h012342);
		pc_step_i = 1'b0;
		ce_i = 1'b1;
		table_op_i = 1'b1;
		for (i = 0; i < 7; i++) begin
			table_offset_i = offs[i];
			#1 chk(prog_addr_o, {8'h00, offs[i]});
			chk({in_vectors_o, in_ivt_o, in_alt_ivt_o}, dec[i]);
			@(negedge clk_i);
		end
		table_page_register_i = 8'h80;
		#1 chk(prog_ok_o, 1'b1);
		chk(prog_addr_o, 24'h800202);
		table_op_i = 1'b0;
		$display("test program space done");
		r = 16'h0002;
		for (i = 0; i < 8; i++) begin
			r = lfsr(r);
			a = {2'b00, r[13:1], 1'b0};
			r = lfsr(r);
			wr(a, r, 1'b0);
			rdc(a, 1'b0, r);
			wr(a | 16'h0001, 16'hc3c3, 1'b1);
			rdc(a, 1'b0, {8'hc3, r[7:0]});
			rdc(a | 16'h0001, 1'b1, 16'h00c3);
			rdc(a, 1'b1, {8'h00, r[7:0]});
		end
		rdc(16'h5000, 1'b0, 16'h0000);
		rdc(16'h7fff, 1'b1, 16'h0000);
		wr(16'h0200, 16'h1234, 1'b0);
		wr(16'h0201, 16'hffff, 1'b0);
		@(negedge clk_i);
		chk(addr_error_o, 1'b0);
		rdc(16'h0200, 1'b0, 16'h1234);
		rdc(16'h0201, 1'b0, 16'h1234);
		$display("test data space done");
		wr(16'h1004, 16'h1111, 1'b0);
		wr(16'h3004, 16'h3333, 1'b0);
		direct_i = 1'b1;
		direct_field_i = 16'h3004;
		rdc(16'h0000, 1'b0, 16'h1111);
		move_op_i = 1'b1;
		rdc(16'h0000, 1'b0, 16'h3333);
		direct_i = 1'b0;
		rdc(16'h8010, 1'b0, 16'h0000);
		window_enable_i = 1'b1;
		window_page_i = 8'h01;
		rdc(16'h8010, 1'b0, pw(24'h010010));
		@(negedge clk_i);
		window_page_i = 8'h80;
		rq = '{1'b1, 1'b0, 16'h8010};
		#1 chk(prog_ok_o, 1'b0);
		@(negedge clk_i);
		rq.valid = 1'b0;
		window_enable_i = 1'b0;
		$display("test direct and window done");
		reg_src_i = 16'h1280;
		ext_op_i = mem_space_pkg::EXT_SIGN;
		#1 chk(ext_result_o, 16'hff80);
		ext_op_i = mem_space_pkg::EXT_ZERO;
		#1 chk(ext_result_o, 16'h0080);
		reg_src_i = 16'hf471;
		ext_op_i = mem_space_pkg::EXT_SIGN;
		#1 chk(ext_result_o, 16'h0071);
		ext_op_i = mem_space_pkg::EXT_NONE;
		#1 chk(ext_result_o, 16'hf471);
		$display("test extend done");
		wrap_up();
	end
endmodule
